// *** logic/ddp_pkg.sv ***
package ddp_pkg;
  // Special-register addresses
  localparam logic [7:0] ADDR_PTR0_LO = 8'h82;
  localparam logic [7:0] ADDR_PTR0_HI = 8'h83;
  localparam logic [7:0] ADDR_PTR1_LO = 8'h84;
  localparam logic [7:0] ADDR_PTR1_HI = 8'h85;
  localparam logic [7:0] ADDR_CONFIG = 8'hA2;

  // Pointer configuration field positions
  localparam int CFG_SEL_BIT = 0;
  localparam int CFG_SIG_BIT = 3;
  localparam int CFG_DEC0_BIT = 4;
  localparam int CFG_UPD0_BIT = 6;

  // Reset values and masks
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WR_MASK = 8'hF9;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [7:0] SWAP_PREFIX = 8'hA5;

  // Pointer-operand instruction requests from the CPU
  typedef enum logic [2:0] {
    DDP_OP_NONE = 3'b000,
    DDP_OP_LOAD = 3'b001,
    DDP_OP_INC = 3'b010,
    DDP_OP_EXTERNAL_DATA_MOVE = 3'b011,
    DDP_OP_CODE_SPACE_READ = 3'b100,
    DDP_OP_JMP = 3'b101
  } ddp_op_t;

  typedef struct packed {
    ddp_op_t op;
    logic swap;
    logic [7:0] acc;
    logic [15:0] data;
  } ddp_inst_t;

  // Memory address issued for a pointer access
  typedef struct packed {
    logic sig;
    logic code;
    logic [15:0] addr;
  } ddp_acc_t;

  // Register-side access
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } ddp_sfr_t;
endpackage

// *** logic/ddp_ptr_step.sv ***
`timescale 1ns/1ps
module ddp_ptr_step
  import ddp_pkg::*;
(
  // Pointer in
  input wire logic [15:0] cur,
  input wire logic dec,
  // Stepped pointer out
  output logic [15:0] stepped
);
  // Full 16-bit step, wraps modulo 65536
  assign stepped = dec ? cur - 16'h0001 : cur + 16'h0001; // see RULE13
endmodule

// *** logic/ddp_unit.sv ***
`timescale 1ns/1ps
// Functional notes
// (RULE1) Two 16-bit pointers at 82H/83H, 84H/85H
// (RULE2) Select bit picks pointer for operand
// (RULE3) Pointer bytes readable, writable at any time
// (RULE4) Config bit 2 always zero
// (RULE5) Swap prefix inverts select for one instruction
// (RULE6) Indirect jump ignores swap prefix
// (RULE7) Decrement bit turns increment into decrement
// (RULE8) Decrement bit follows resolved target pointer
// (RULE9) Update bit enables post-access pointer step
// (RULE10) Post-access step direction follows decrement bit
// (RULE11) Signature enable steers accesses to signature
// (RULE12) Reset clears configuration register
// (RULE13) Steps wrap modulo 65536 with carry
module ddp_unit
  import ddp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Special-register access
  input wire ddp_sfr_t sfrReq,
  output logic [7:0] sfrRdData,
  output logic sfrRdValid,
  // Pointer instruction request
  input wire logic instValid,
  input wire ddp_inst_t inst,
  // Memory access request
  output logic accValid,
  output ddp_acc_t acc,
  // Current state
  output logic [15:0] activePtr,
  output logic [7:0] pointerConfig
);

  // Address hit test, used by the write decoder and the byteRead_a check; the read mux uses a case
  function automatic logic regHit(input logic [7:0] a,
                                  input logic [7:0] off);
    regHit = (a == off);
  endfunction

  logic [15:0] ptr_r [2];
  logic [15:0] ptr_nxt [2];
  logic [15:0] stepped [2];
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic rdValid_r;
  logic accValid_r;
  logic accValid_nxt;
  ddp_acc_t acc_r;
  ddp_acc_t acc_nxt;

  // Request decode
  wire logic selBit = cfg_r[CFG_SEL_BIT];
  wire logic isJmp = instValid && (inst.op == DDP_OP_JMP);
  wire logic isInc = instValid && (inst.op == DDP_OP_INC);
  wire logic isLoad = instValid && (inst.op == DDP_OP_LOAD);
  wire logic isMovx = instValid && (inst.op == DDP_OP_EXTERNAL_DATA_MOVE);
  wire logic isMovc = instValid && (inst.op == DDP_OP_CODE_SPACE_READ);
  wire logic isMem = isMovx || isMovc;
  wire logic swapOk = inst.swap && !isJmp; // see RULE6
  wire logic tgtSel = selBit ^ swapOk; // see RULE2 see RULE5
  wire logic tgtDec = cfg_r[CFG_DEC0_BIT + int'(tgtSel)]; // see RULE8
  wire logic tgtUpd = cfg_r[CFG_UPD0_BIT + int'(tgtSel)];
  wire logic [15:0] tgtPtr = ptr_r[tgtSel];
  wire logic [15:0] offPtr = tgtPtr + {8'h00, inst.acc};

  // Register write decode
  wire logic wrCfg = sfrReq.wrEn && regHit(sfrReq.addr, ADDR_CONFIG);
  wire logic [3:0] wrByte = {
    sfrReq.wrEn && regHit(sfrReq.addr, ADDR_PTR1_HI),
    sfrReq.wrEn && regHit(sfrReq.addr, ADDR_PTR1_LO),
    sfrReq.wrEn && regHit(sfrReq.addr, ADDR_PTR0_HI),
    sfrReq.wrEn && regHit(sfrReq.addr, ADDR_PTR0_LO)
  };

  // Per-pointer step logic and next value
  generate
    for (genvar i = 0; i < 2; i++) begin : gPtr
      wire logic hitMe = (tgtSel == 1'(i));
      wire logic stepMe = hitMe && (isInc || (isMem && tgtUpd));

      ddp_ptr_step uStep (
        .cur(ptr_r[i]),
        .dec(cfg_r[CFG_DEC0_BIT + i]), // see RULE7 see RULE10
        .stepped(stepped[i])
      );

      // Register writes win over a same-cycle instruction update
      always_comb begin
        if (wrByte[2*i]) begin
          ptr_nxt[i] = {ptr_r[i][15:8], sfrReq.wrData}; // see RULE3
        end else if (wrByte[2*i+1]) begin
          ptr_nxt[i] = {sfrReq.wrData, ptr_r[i][7:0]}; // see RULE1
        end else if (hitMe && isLoad) begin
          ptr_nxt[i] = inst.data;
        end else if (stepMe) begin
          ptr_nxt[i] = stepped[i]; // see RULE9
        end else begin
          ptr_nxt[i] = ptr_r[i];
        end
      end

      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          ptr_r[i] <= PTR_RESET;
        end else begin
          ptr_r[i] <= ptr_nxt[i];
        end
      end
    end
  endgenerate

  // Config write keeps bits 2 and 1 at zero
  assign cfg_nxt = wrCfg ? (sfrReq.wrData & CFG_WR_MASK) : cfg_r; // see RULE4

  // Register read mux
  always_comb begin
    case (sfrReq.addr)
      ADDR_PTR0_LO: rdData_nxt = ptr_r[0][7:0];
      ADDR_PTR0_HI: rdData_nxt = ptr_r[0][15:8];
      ADDR_PTR1_LO: rdData_nxt = ptr_r[1][7:0]; // see RULE3
      ADDR_PTR1_HI: rdData_nxt = ptr_r[1][15:8];
      ADDR_CONFIG: rdData_nxt = cfg_r;
      default: rdData_nxt = RD_UNMAPPED;
    endcase
  end

  // Memory access address and target space
  always_comb begin
    acc_nxt.sig = cfg_r[CFG_SIG_BIT] && isMem; // see RULE11
    acc_nxt.code = isMovc || isJmp;
    acc_nxt.addr = (isMovc || isJmp) ? offPtr : tgtPtr;
    if (isJmp) begin
      acc_nxt.addr = ptr_r[selBit] + {8'h00, inst.acc}; // see RULE6
    end
  end
  assign accValid_nxt = isMem || isJmp;

  // Config, read and access registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= CFG_RESET; // see RULE12
      rdData_r <= RD_UNMAPPED;
      rdValid_r <= 1'b0;
      accValid_r <= 1'b0;
      acc_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      rdData_r <= sfrReq.rdEn ? rdData_nxt : rdData_r;
      rdValid_r <= sfrReq.rdEn;
      accValid_r <= accValid_nxt;
      acc_r <= accValid_nxt ? acc_nxt : acc_r;
    end
  end

  // Outputs
  assign sfrRdData = rdData_r;
  assign sfrRdValid = rdValid_r;
  assign accValid = accValid_r;
  assign acc = acc_r;
  assign activePtr = ptr_r[selBit];
  assign pointerConfig = cfg_r;

  // Checks
  wire logic noWr = !sfrReq.wrEn;

  cfgFixed_a: assert property ( // see RULE4
    @(posedge core_clk) disable iff (!arst_n)
    cfg_r[2:1] == 2'b00)
    else $error("config bits 2..1 not zero");

  swapKeep_a: assert property ( // see RULE5
    @(posedge core_clk) disable iff (!arst_n)
    instValid && inst.swap && noWr |=> $stable(cfg_r[CFG_SEL_BIT]))
    else $error("swap prefix changed stored select");

  swapAddr_a: assert property ( // see RULE5
    @(posedge core_clk) disable iff (!arst_n)
    isMovx && inst.swap |=>
      acc_r.addr == $past(ptr_r[!cfg_r[CFG_SEL_BIT]]))
    else $error("swap access used wrong pointer");

  jmpSel_a: assert property ( // see RULE6
    @(posedge core_clk) disable iff (!arst_n)
    isJmp |=> accValid_r && acc_r.addr ==
      $past(ptr_r[cfg_r[CFG_SEL_BIT]] + {8'h00, inst.acc}))
    else $error("jump used wrong pointer");

  incDir_a: assert property ( // see RULE7
    @(posedge core_clk) disable iff (!arst_n)
    isInc && noWr |=> ptr_r[$past(tgtSel)] ==
      ($past(tgtDec) ? $past(tgtPtr) - 16'h0001
                     : $past(tgtPtr) + 16'h0001))
    else $error("increment direction wrong");

  noUpd_a: assert property ( // see RULE9
    @(posedge core_clk) disable iff (!arst_n)
    isMem && !tgtUpd && noWr |=> $stable(ptr_r[0]) && $stable(ptr_r[1]))
    else $error("pointer moved without update bit");

  postStep_a: assert property ( // see RULE10
    @(posedge core_clk) disable iff (!arst_n)
    isMem && tgtUpd && noWr |=> ptr_r[$past(tgtSel)] ==
      ($past(tgtDec) ? $past(tgtPtr) - 16'h0001
                     : $past(tgtPtr) + 16'h0001))
    else $error("post-access step wrong");

  sigSteer_a: assert property ( // see RULE11
    @(posedge core_clk) disable iff (!arst_n)
    isMem |=> acc_r.sig == $past(cfg_r[CFG_SIG_BIT]))
    else $error("signature steering wrong");

  byteRead_a: assert property ( // see RULE3
    @(posedge core_clk) disable iff (!arst_n)
    sfrReq.rdEn && regHit(sfrReq.addr, ADDR_PTR1_HI) |=>
      sfrRdValid && sfrRdData == $past(ptr_r[1][15:8]))
    else $error("pointer byte read wrong");

  byteWrite_a: assert property ( // see RULE1
    @(posedge core_clk) disable iff (!arst_n)
    wrByte[0] |=> ptr_r[0][7:0] == $past(sfrReq.wrData))
    else $error("pointer byte write lost");

  selAddr_a: assert property ( // see RULE2
    @(posedge core_clk) disable iff (!arst_n)
    isMovx && !inst.swap |=>
      acc_r.addr == $past(ptr_r[cfg_r[CFG_SEL_BIT]]))
    else $error("plain access used wrong pointer");

  loadTgt_a: assert property ( // see RULE2
    @(posedge core_clk) disable iff (!arst_n)
    isLoad && noWr |=> ptr_r[$past(tgtSel)] == $past(inst.data))
    else $error("load went to wrong pointer");

  cfgWrite_a: assert property ( // see RULE4
    @(posedge core_clk) disable iff (!arst_n)
    wrCfg |=> cfg_r == ($past(sfrReq.wrData) & CFG_WR_MASK))
    else $error("config write not masked");

  cfgHold_a: assert property ( // see RULE5
    @(posedge core_clk) disable iff (!arst_n)
    !wrCfg |=> $stable(cfg_r))
    else $error("config changed without write");

  swapInc_a: assert property ( // see RULE5
    @(posedge core_clk) disable iff (!arst_n)
    isInc && inst.swap && noWr |=>
      (cfg_r[CFG_SEL_BIT] ? $stable(ptr_r[1]) : $stable(ptr_r[0])))
    else $error("swap increment moved stored pointer");

  decOwn_a: assert property ( // see RULE8
    @(posedge core_clk) disable iff (!arst_n)
    isInc && noWr && tgtSel |=> ptr_r[1] ==
      ($past(cfg_r[CFG_DEC0_BIT + 1]) ? $past(ptr_r[1]) - 16'h0001
                                      : $past(ptr_r[1]) + 16'h0001))
    else $error("pointer one used wrong decrement bit");

  jmpHold_a: assert property ( // see RULE6
    @(posedge core_clk) disable iff (!arst_n)
    isJmp && noWr |=> $stable(ptr_r[0]) && $stable(ptr_r[1]))
    else $error("jump moved a pointer");

  sigClear_a: assert property ( // see RULE11
    @(posedge core_clk) disable iff (!arst_n)
    (isMem && !cfg_r[CFG_SIG_BIT]) || isJmp |=> !acc_r.sig)
    else $error("access steered to signature");

  rdPulse_a: assert property ( // see RULE3
    @(posedge core_clk) disable iff (!arst_n)
    sfrRdValid == $past(sfrReq.rdEn))
    else $error("read valid not one cycle after strobe");

  accPulse_a: assert property ( // see RULE9
    @(posedge core_clk) disable iff (!arst_n)
    accValid == $past(isMem || isJmp))
    else $error("access valid not one cycle after request");

  resetCfg_a: assert property ( // see RULE12
    @(posedge core_clk)
    $rose(arst_n) |-> cfg_r == CFG_RESET)
    else $error("config not cleared by reset");

  resetPtr_a: assert property ( // see RULE1
    @(posedge core_clk)
    $rose(arst_n) |-> ptr_r[0] == PTR_RESET && ptr_r[1] == PTR_RESET)
    else $error("pointers not cleared by reset");

  wrapUp_a: assert property ( // see RULE13
    @(posedge core_clk) disable iff (!arst_n)
    isInc && noWr && !tgtDec && tgtPtr == 16'hFFFF |=>
      ptr_r[$past(tgtSel)] == 16'h0000)
    else $error("increment did not wrap to zero");

  wrapDown_a: assert property ( // see RULE13
    @(posedge core_clk) disable iff (!arst_n)
    isInc && noWr && tgtDec && tgtPtr == 16'h0000 |=>
      ptr_r[$past(tgtSel)] == 16'hFFFF)
    else $error("decrement did not wrap to all ones");
endmodule

// *** tb/ddp_cpu_model.sv ***
`timescale 1ns/1ps
module ddp_cpu_model
  import ddp_pkg::*;
(
  // Clock and read data
  input wire logic core_clk,
  input wire logic [7:0] sfrRdData,
  input wire logic sfrRdValid,
  // Requests
  output ddp_sfr_t sfrReq,
  output logic instValid,
  output ddp_inst_t inst
);
  // Idle requests from time zero
  initial begin
    sfrReq = '0;
    instValid = 1'b0;
    inst = '0;
  end
  // One-cycle register write, then an idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrReq = '{1'b1, 1'b0, a, d};
    @(negedge core_clk);
    sfrReq = '0;
    @(negedge core_clk);
  endtask
  // One-cycle read; data and valid taken while the pulse stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    sfrReq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk);
    d = sfrRdData;
    v = sfrRdValid;
    sfrReq = '0;
    @(negedge core_clk);
  endtask
  // One pointer instruction
  task automatic run(input ddp_op_t op, input logic sw);
    inst = '{op, sw, 8'h10, 16'h1234};
    instValid = 1'b1;
    @(negedge core_clk);
    instValid = 1'b0;
  endtask
endmodule

// *** tb/dual_data_pointer_unit_test.sv ***
`timescale 1ns/1ps
module dual_data_pointer_unit_test;
  import ddp_pkg::*;
  typedef struct packed {
    logic [7:0] cfg;
    ddp_op_t op;
    logic sw;
    logic sig;
    logic [15:0] addr;
    logic [15:0] p0;
    logic [15:0] p1;
  } ddp_row_t;
  // Each row starts from pointer zero 1000, pointer one 2000
  localparam ddp_row_t ROWS [12] = '{
    '{8'h00, DDP_OP_EXTERNAL_DATA_MOVE, 1'b0, 1'b0, 16'h1000, 16'h1000, 16'h2000},
    '{8'h40, DDP_OP_EXTERNAL_DATA_MOVE, 1'b0, 1'b0, 16'h1000, 16'h1001, 16'h2000},
    '{8'h50, DDP_OP_EXTERNAL_DATA_MOVE, 1'b0, 1'b0, 16'h1000, 16'h0FFF, 16'h2000},
    '{8'h81, DDP_OP_EXTERNAL_DATA_MOVE, 1'b0, 1'b0, 16'h2000, 16'h1000, 16'h2001},
    '{8'h61, DDP_OP_EXTERNAL_DATA_MOVE, 1'b1, 1'b0, 16'h1000, 16'h1001, 16'h2000},
    '{8'h08, DDP_OP_CODE_SPACE_READ, 1'b0, 1'b1, 16'h1010, 16'h1000, 16'h2000},
    '{8'h01, DDP_OP_JMP, 1'b1, 1'b0, 16'h2010, 16'h1000, 16'h2000},
    '{8'h10, DDP_OP_INC, 1'b0, 1'b0, 16'h0000, 16'h0FFF, 16'h2000},
    '{8'h21, DDP_OP_INC, 1'b1, 1'b0, 16'h0000, 16'h1001, 16'h2000},
    '{8'h00, DDP_OP_LOAD, 1'b1, 1'b0, 16'h0000, 16'h1000, 16'h1234},
    '{8'hC1, DDP_OP_CODE_SPACE_READ, 1'b1, 1'b0, 16'h1010, 16'h1001, 16'h2000},
    '{8'h80, DDP_OP_EXTERNAL_DATA_MOVE, 1'b0, 1'b0, 16'h1000, 16'h1000, 16'h2000}
  };
  logic coreClk, arstN, instValid, accValid, sfrRdValid, v;
  ddp_sfr_t sfrReq;
  ddp_inst_t inst;
  ddp_acc_t acc;
  logic [7:0] sfrRdData, pointerConfig, b;
  logic [15:0] activePtr, p0, p1;
  int failures, nCompared;
  ddp_row_t r;

  ddp_unit u_dut (.core_clk(coreClk), .arst_n(arstN), .sfrReq(sfrReq),
    .sfrRdData(sfrRdData), .sfrRdValid(sfrRdValid),
    .instValid(instValid), .inst(inst), .accValid(accValid),
    .acc(acc), .activePtr(activePtr), .pointerConfig(pointerConfig));
  ddp_cpu_model u_cpu (.core_clk(coreClk), .sfrRdData(sfrRdData),
    .sfrRdValid(sfrRdValid), .sfrReq(sfrReq), .instValid(instValid),
    .inst(inst));

  // 200 MHz clock
  initial begin
    coreClk = 1'b0;
    forever #2.5 coreClk = ~coreClk;
  end
  // Comparison with mismatch report
  task automatic chk(input string n, input logic [15:0] got, exp);
    nCompared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Pointer byte access at the fixed addresses
  task automatic setp(input logic [15:0] a, input logic [15:0] c);
    u_cpu.wr(ADDR_PTR0_LO, a[7:0]);
    u_cpu.wr(ADDR_PTR0_HI, a[15:8]);
    u_cpu.wr(ADDR_PTR1_LO, c[7:0]);
    u_cpu.wr(ADDR_PTR1_HI, c[15:8]);
  endtask
  task automatic getp(output logic [15:0] a, output logic [15:0] c);
    logic [3:0] ok;
    u_cpu.rd(ADDR_PTR0_LO, a[7:0], ok[0]);
    u_cpu.rd(ADDR_PTR0_HI, a[15:8], ok[1]);
    u_cpu.rd(ADDR_PTR1_LO, c[7:0], ok[2]);
    u_cpu.rd(ADDR_PTR1_HI, c[15:8], ok[3]);
    chk("read valid", {12'h000, ok}, 16'h000F);
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog cuts a hang short
  initial begin
    #20000;
    failures++;
    end_of_test();
  end
  // Main sequence
  initial begin
    failures = 0;
    nCompared = 0;
    arstN = 1'b0;
    repeat (6) @(negedge coreClk);
    arstN = 1'b1;
    u_cpu.rd(ADDR_CONFIG, b, v);
    chk("config valid", {15'h0, v}, 16'h0001);
    chk("config reset", {8'h00, b}, 16'h0000);
    getp(p0, p1);
    chk("ptr0 reset", p0, 16'h0000);
    chk("ptr1 reset", p1, 16'h0000);
    $display("reset test done");
    foreach (ROWS[i]) begin
      r = ROWS[i];
      setp(16'h1000, 16'h2000);
      u_cpu.wr(ADDR_CONFIG, r.cfg);
      chk("active", activePtr, r.cfg[0] ? 16'h2000 : 16'h1000);
      u_cpu.run(r.op, r.sw);
      chk("acc valid", {15'h0, accValid}, {15'h0, r.addr != 16'h0});
      if (r.addr != 16'h0) begin
        chk("acc addr", acc.addr, r.addr);
        chk("acc sig", {15'h0, acc.sig}, {15'h0, r.sig});
        chk("acc code", {15'h0, acc.code},
            {15'h0, r.op inside {DDP_OP_CODE_SPACE_READ, DDP_OP_JMP}});
      end
      getp(p0, p1);
      chk("ptr0", p0, r.p0);
      chk("ptr1", p1, r.p1);
      chk("config kept", {8'h00, pointerConfig}, {8'h00, r.cfg});
    end
    $display("table test done");
    u_cpu.wr(ADDR_CONFIG, 8'hFF);
    u_cpu.rd(ADDR_CONFIG, b, v);
    chk("config mask", {8'h00, b}, 16'h00F9);
    u_cpu.wr(ADDR_CONFIG, b + 8'h01);
    u_cpu.rd(ADDR_CONFIG, b, v);
    chk("config incr", {8'h00, b}, 16'h00F8);
    u_cpu.rd(8'h86, b, v);
    chk("unmapped", {8'h00, b}, 16'h0000);
    $display("config test done");
    setp(16'hFFFF, 16'h0000);
    u_cpu.wr(ADDR_CONFIG, 8'h20);
    u_cpu.run(DDP_OP_INC, 1'b0);
    @(negedge coreClk);
    u_cpu.run(DDP_OP_INC, 1'b1);
    getp(p0, p1);
    chk("wrap up", p0, 16'h0000);
    chk("wrap down", p1, 16'hFFFF);
    $display("wrap test done");
    // Mid-run reset clears config, pointers and registered outputs
    u_cpu.wr(ADDR_CONFIG, 8'hD9);
    chk("active before", activePtr, 16'hFFFF);
    arstN = 1'b0;
    repeat (2) @(negedge coreClk);
    arstN = 1'b1;
    chk("config rst", {8'h00, pointerConfig}, 16'h0000);
    chk("rd data rst", {8'h00, sfrRdData}, 16'h0000);
    chk("acc rst", acc.addr, 16'h0000);
    getp(p0, p1);
    chk("ptr0 rst", p0, 16'h0000);
    chk("ptr1 rst", p1, 16'h0000);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
